// File: rtl/plebk_pkg.sv
package plebk_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam logic [3:0] OFF_PERIOD   = 4'h0;
   localparam logic [3:0] OFF_SEVT     = 4'h4;
   localparam logic [3:0] OFF_LEBCTL   = 4'h8;
   localparam logic [3:0] OFF_LEBDLY   = 4'hc;
   localparam logic [3:0] OFF_AUX      = 4'h0;
   localparam logic [15:0] RST_PERIOD  = 16'hfff8;
   localparam logic [15:0] RST_SEVT    = 16'h0000;
   localparam logic [15:0] RST_LEBCTL  = 16'h0000;
   localparam logic [15:0] RST_LEBDLY  = 16'h0000;
   localparam logic [15:0] RST_AUX     = 16'h0000;
   localparam logic [15:0] LEBCTL_MASK = 16'hfc3f;
   localparam logic [15:0] LEBDLY_MASK = 16'h0fff;
   localparam logic [15:0] AUX_MASK    = 16'h0003;
   localparam int unsigned B_HRISE   = 15;
   localparam int unsigned B_HFALL   = 14;
   localparam int unsigned B_LRISE   = 13;
   localparam int unsigned B_LFALL   = 12;
   localparam int unsigned B_FLTEN   = 11;
   localparam int unsigned B_CLEN    = 10;
   localparam int unsigned B_SIGHI   = 5;
   localparam int unsigned B_SIGLO   = 4;
   localparam int unsigned B_HHI     = 3;
   localparam int unsigned B_HLO     = 2;
   localparam int unsigned B_LHI     = 1;
   localparam int unsigned B_LLO     = 0;
   localparam int unsigned SEL_W     = 2;
   localparam int unsigned DLY_W     = 12;
endpackage

// File: rtl/plebk_top.sv
// Contract
// RULE1: hold 16-bit master time base period value, read/write
// RULE2: hold 16-bit special event compare value, compared against time base
// RULE3: enabled high-side rising edge starts blanking counter
// RULE4: enabled high-side falling edge starts blanking counter
// RULE5: enabled low-side rising edge starts blanking counter
// RULE6: enabled low-side falling edge starts blanking counter
// RULE7: edge blanking masks fault input only when fault enable set
// RULE8: edge blanking masks current-limit input only when its enable set
// RULE9: mask both inputs while selected blanking signal high, if enabled
// RULE10: mask both inputs while selected blanking signal low, if enabled
// RULE11: mask both inputs while high-side output high, if enabled
// RULE12: mask both inputs while high-side output low, if enabled
// RULE13: mask both inputs while low-side output high, if enabled
// RULE14: mask both inputs while low-side output low, if enabled
// RULE15: blanking signal chosen by selector field in auxiliary control register
// RULE16: control bits 9-6 ignore writes and read as zero
// RULE17: blanking lasts programmed interval; new enabled edge restarts it
//
// The implementer's own choices: the address map and the Wishbone slave port.
module plebk_top (
   input  wire logic                            clk_in,
   input  wire logic                            rst_in,
   input  wire logic                            wb_cyc_in,
   input  wire logic                            wb_stb_in,
   input  wire logic                            wb_we_in,
   input  wire logic [7:0]                      wb_adr_in,
   input  wire logic [3:0]                      wb_sel_in,
   input  wire logic [31:0]                     wb_dat_in,
   output logic      [31:0]                     wb_dat_out,
   output logic                                 wb_ack_out,
   input  wire logic [15:0]                     primary_master_timer_in,
   output logic                                 special_event_out,
   output logic      [15:0]                     master_period_value_out,
   input  wire logic                            high_side_output_in,
   input  wire logic                            low_side_output_in,
   input  wire logic [(1 << plebk_pkg::SEL_W)-1:0] blank_sources_in,
   input  wire logic                            fault_in,
   input  wire logic                            current_limit_in,
   output logic                                 fault_out,
   output logic                                 current_limit_out,
   output logic                                 blanking_active_out
);
   import plebk_pkg::*;

   typedef struct packed {
      logic [15:0]       period;
      logic [15:0]       sevt;
      logic [15:0]       lebctl;
      logic [15:0]       lebdly;
      logic [15:0]       aux;
      logic [31:0]       rdat;
      logic              ack;
      logic              h_d;
      logic              l_d;
      logic [DLY_W-1:0]  cnt;
      logic              sevt_p;
      logic              flt_q;
      logic              cl_q;
      logic              blank_q;
   } plebk_state_t;

   plebk_state_t st_r;
   plebk_state_t st_nxt;

   logic             req;
   logic             wr;
   logic [3:0]       adr;
   logic             aux_sel;
   logic [15:0]      wmask;
   logic             h_rise;
   logic             h_fall;
   logic             l_rise;
   logic             l_fall;
   logic             trig;
   logic             edge_blank;
   logic             sel_sig;
   logic             lvl_blank;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [15:0] m);
      merge = (old & ~m) | (d[15:0] & m);
   endfunction

   assign req     = wb_cyc_in & wb_stb_in & ~st_r.ack;
   assign wr      = req & wb_we_in;
   assign adr     = wb_adr_in[3:0];
   assign aux_sel = wb_adr_in[4];
   assign wmask   = {{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

   assign h_rise = high_side_output_in & ~st_r.h_d;
   assign h_fall = ~high_side_output_in & st_r.h_d;
   assign l_rise = low_side_output_in & ~st_r.l_d;
   assign l_fall = ~low_side_output_in & st_r.l_d;
   assign trig   = (h_rise & st_r.lebctl[B_HRISE])   // [RULE3]
                 | (h_fall & st_r.lebctl[B_HFALL])   // [RULE4]
                 | (l_rise & st_r.lebctl[B_LRISE])   // [RULE5]
                 | (l_fall & st_r.lebctl[B_LFALL]);  // [RULE6]
   assign edge_blank = trig | (st_r.cnt != '0);      // [RULE17]
   assign sel_sig    = blank_sources_in[st_r.aux[SEL_W-1:0]];  // [RULE15]
   assign lvl_blank  = (st_r.lebctl[B_SIGHI] & sel_sig)                 // [RULE9]
                     | (st_r.lebctl[B_SIGLO] & ~sel_sig)                // [RULE10]
                     | (st_r.lebctl[B_HHI] & high_side_output_in)       // [RULE11]
                     | (st_r.lebctl[B_HLO] & ~high_side_output_in)      // [RULE12]
                     | (st_r.lebctl[B_LHI] & low_side_output_in)        // [RULE13]
                     | (st_r.lebctl[B_LLO] & ~low_side_output_in);      // [RULE14]

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = req;
      st_nxt.h_d = high_side_output_in;
      st_nxt.l_d = low_side_output_in;
      if (wr && !aux_sel) begin
         case (adr)
            OFF_PERIOD: st_nxt.period = merge(st_r.period, wb_dat_in, wmask);  // [RULE1]
            OFF_SEVT:   st_nxt.sevt = merge(st_r.sevt, wb_dat_in, wmask);      // [RULE2]
            OFF_LEBCTL: st_nxt.lebctl = merge(st_r.lebctl, wb_dat_in,
                                              wmask & LEBCTL_MASK);          // [RULE16]
            OFF_LEBDLY: st_nxt.lebdly = merge(st_r.lebdly, wb_dat_in,
                                              wmask & LEBDLY_MASK);
            default: ;
         endcase
      end
      if (wr && aux_sel && adr == OFF_AUX) begin
         st_nxt.aux = merge(st_r.aux, wb_dat_in, wmask & AUX_MASK);
      end
      st_nxt.rdat = 32'h0000_0000;
      if (req && !aux_sel) begin
         case (adr)
            OFF_PERIOD: st_nxt.rdat = {16'h0000, st_r.period};
            OFF_SEVT:   st_nxt.rdat = {16'h0000, st_r.sevt};
            OFF_LEBCTL: st_nxt.rdat = {16'h0000, st_r.lebctl & LEBCTL_MASK};
            OFF_LEBDLY: st_nxt.rdat = {16'h0000, st_r.lebdly};
            default:    st_nxt.rdat = 32'h0000_0000;
         endcase
      end else if (req && adr == OFF_AUX) begin
         st_nxt.rdat = {16'h0000, st_r.aux};
      end
      // counter reloads on each enabled edge, then runs down to zero
      if (trig) begin
         st_nxt.cnt = st_r.lebdly[DLY_W-1:0];  // [RULE17]
      end else if (st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
      st_nxt.sevt_p  = (primary_master_timer_in == st_r.sevt);  // [RULE2]
      st_nxt.blank_q = edge_blank | lvl_blank;
      st_nxt.flt_q   = fault_in & ~lvl_blank
                     & ~(edge_blank & st_r.lebctl[B_FLTEN]);    // [RULE7]
      st_nxt.cl_q    = current_limit_in & ~lvl_blank
                     & ~(edge_blank & st_r.lebctl[B_CLEN]);     // [RULE8]
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_r        <= '0;
         st_r.period <= RST_PERIOD;
         st_r.sevt   <= RST_SEVT;
         st_r.lebctl <= RST_LEBCTL;
         st_r.lebdly <= RST_LEBDLY;
         st_r.aux    <= RST_AUX;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_out              = st_r.rdat;
   assign wb_ack_out              = st_r.ack;
   assign special_event_out       = st_r.sevt_p;
   assign master_period_value_out = st_r.period;
   assign fault_out               = st_r.flt_q;
   assign current_limit_out       = st_r.cl_q;
   assign blanking_active_out     = st_r.blank_q;

   // register bus: the ack gate stops a held request from being taken twice
   a_ack_follows: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE1]
      req |=> wb_ack_out)
      else $error("request not acknowledged");
   a_ack_quiet: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE1]
      !req |=> !wb_ack_out)
      else $error("ack without request");
   a_ack_single: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE1]
      wb_ack_out |=> !wb_ack_out)
      else $error("ack held too long");
   a_rdat_upper: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE1]
      wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_period_write: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE1]
      wr && !aux_sel && adr == OFF_PERIOD && wb_sel_in[1:0] == 2'h3
      |=> master_period_value_out == $past(wb_dat_in[15:0]))
      else $error("period write lost");
   a_period_hold: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE1]
      !(wr && !aux_sel && adr == OFF_PERIOD) |=> $stable(master_period_value_out))
      else $error("period changed without write");
   a_sevt_write: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE2]
      wr && !aux_sel && adr == OFF_SEVT && wb_sel_in[1:0] == 2'h3
      |=> st_r.sevt == $past(wb_dat_in[15:0]))
      else $error("compare write lost");
   a_sevt_pulse: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE2]
      primary_master_timer_in == st_r.sevt |=> special_event_out)
      else $error("special event missed");
   a_sevt_quiet: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE2]
      primary_master_timer_in != st_r.sevt |=> !special_event_out)
      else $error("special event without match");
   a_ctl_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE16]
      (st_r.lebctl & ~LEBCTL_MASK) == 16'h0000)
      else $error("reserved control bits not zero");
   a_ctl_read_gap: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE16]
      req && !aux_sel && adr == OFF_LEBCTL |=> wb_dat_out[9:6] == 4'h0)
      else $error("reserved control bits read nonzero");
   a_aux_reserved: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE15]
      (st_r.aux & ~AUX_MASK) == 16'h0000)
      else $error("reserved selector bits not zero");
   a_dly_reserved: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE17]
      (st_r.lebdly & ~LEBDLY_MASK) == 16'h0000)
      else $error("reserved interval bits not zero");

   // edge blanking: enabled edges load the counter, which runs down to zero
   sequence s_edge_seen;
      trig;
   endsequence
   sequence s_count_loaded;
      st_r.cnt == $past(st_r.lebdly[DLY_W-1:0]);
   endsequence
   sequence s_last_tick;
      !trig && st_r.cnt == 12'h001;
   endsequence
   sequence s_released;
      !trig && !lvl_blank;
   endsequence
   a_hrise_starts: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE3]
      h_rise && st_r.lebctl[B_HRISE] && st_r.lebdly != 16'h0000
      |=> st_r.cnt == $past(st_r.lebdly[DLY_W-1:0]))
      else $error("high rise did not load counter");
   a_hfall_starts: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE4]
      h_fall && st_r.lebctl[B_HFALL] |=> st_r.cnt == $past(st_r.lebdly[DLY_W-1:0]))
      else $error("high fall did not load counter");
   a_lrise_starts: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE5]
      l_rise && st_r.lebctl[B_LRISE] |=> st_r.cnt == $past(st_r.lebdly[DLY_W-1:0]))
      else $error("low rise did not load counter");
   a_lfall_starts: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE6]
      l_fall && st_r.lebctl[B_LFALL] |=> st_r.cnt == $past(st_r.lebdly[DLY_W-1:0]))
      else $error("low fall did not load counter");
   a_edge_loads: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE17]
      s_edge_seen |=> s_count_loaded)
      else $error("enabled edge did not restart interval");
   a_counter_idle: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE3][RULE4]
      !trig && st_r.cnt == '0 |=> st_r.cnt == '0)
      else $error("counter started without enabled edge");
   a_count_down: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE17]
      !trig && st_r.cnt != '0 |=> st_r.cnt == $past(st_r.cnt) - 1'b1)
      else $error("blanking counter did not run down");
   a_expire_release: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE17]
      s_last_tick ##1 s_released
      |=> fault_out == $past(fault_in) && current_limit_out == $past(current_limit_in))
      else $error("inputs still blanked after interval");
   a_fault_masked: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE7]
      edge_blank && st_r.lebctl[B_FLTEN] |=> !fault_out)
      else $error("fault passed during blanking");
   a_cl_masked: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE8]
      edge_blank && st_r.lebctl[B_CLEN] |=> !current_limit_out)
      else $error("current limit passed during blanking");
   a_active_edge: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE17]
      edge_blank |=> blanking_active_out)
      else $error("edge blanking not flagged");

   // level blanking and pass-through
   a_sig_high: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE9]
      st_r.lebctl[B_SIGHI] && sel_sig |=> !fault_out && !current_limit_out)
      else $error("signal high blanking failed");
   a_sig_low: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE10]
      st_r.lebctl[B_SIGLO] && !sel_sig |=> !fault_out && !current_limit_out)
      else $error("signal low blanking failed");
   a_hs_high: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE11]
      st_r.lebctl[B_HHI] && high_side_output_in |=> !fault_out && !current_limit_out)
      else $error("high side high blanking failed");
   a_hs_low: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE12]
      st_r.lebctl[B_HLO] && !high_side_output_in |=> !fault_out && !current_limit_out)
      else $error("high side low blanking failed");
   a_ls_high: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE13]
      st_r.lebctl[B_LHI] && low_side_output_in |=> !fault_out && !current_limit_out)
      else $error("low side high blanking failed");
   a_ls_low: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE14]
      st_r.lebctl[B_LLO] && !low_side_output_in |=> !fault_out && !current_limit_out)
      else $error("low side low blanking failed");
   a_sel_source: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE15]
      st_r.lebctl[B_SIGHI] && blank_sources_in[st_r.aux[SEL_W-1:0]] |=> blanking_active_out)
      else $error("selected source not used");
   a_sel_low: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE15]
      st_r.lebctl[B_SIGLO] && !blank_sources_in[st_r.aux[SEL_W-1:0]] |=> blanking_active_out)
      else $error("selected source low not used");
   a_lvl_active: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE11]
      lvl_blank |=> blanking_active_out)
      else $error("level blanking not flagged");
   a_fault_pass: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE7]
      !lvl_blank && !st_r.lebctl[B_FLTEN] |=> fault_out == $past(fault_in))
      else $error("fault masked while disabled");
   a_cl_pass: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE8]
      !lvl_blank && !st_r.lebctl[B_CLEN] |=> current_limit_out == $past(current_limit_in))
      else $error("current limit masked while disabled");
   a_idle_pass: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE7][RULE8]
      !edge_blank && !lvl_blank
      |=> fault_out == $past(fault_in) && current_limit_out == $past(current_limit_in))
      else $error("unblanked input not passed");
   a_quiet_no_blank: assert property (@(posedge clk_in) disable iff (rst_in)  // [RULE17]
      !edge_blank && !lvl_blank |=> !blanking_active_out)
      else $error("blanking flagged while idle");
endmodule

// File: test/plebk_stage.sv
module plebk_stage (
   input  wire logic       clk_in,
   input  wire logic [1:0] pwm_cmd_in,
   input  wire logic       trip_cmd_in,
   input  wire logic [3:0] src_cmd_in,
   output logic            high_side_out,
   output logic            low_side_out,
   output logic            fault_out,
   output logic            current_limit_out,
   output logic [3:0]      sources_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // power stage and sensors answer one clock after the command
   always_ff @(posedge clk_in) begin
      {high_side_out, low_side_out} <= pwm_cmd_in;
      fault_out <= trip_cmd_in;
      current_limit_out <= trip_cmd_in;
      sources_out <= src_cmd_in;
   end
endmodule

// File: test/plebk_top_tb.sv
module plebk_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [15:0] c; logic [1:0] a; logic [1:0] p; logic [3:0] s; logic m;} plebk_row_t;
   logic        clk_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0, trip = 1;
   logic [7:0]  adr = 0;
   logic [31:0] wdat = 0, rdat;
   logic [15:0] tmr = 0, per, rd;
   logic [1:0]  pwm = 0;
   logic [3:0]  src = 0, srcs, sel = 4'h3;
   logic        ack, sev, hs, ls, flt, cl, flo, clo, bla;
   int          err_total = 0, tests_run = 0, fl, cn;
   plebk_row_t  rows [10] = '{'{16'h0020, 1, 0, 4'h2, 1}, '{16'h0020, 1, 0, 4'hd, 0},
      '{16'h0010, 2, 0, 4'hb, 1}, '{16'h0008, 0, 2, 0, 1}, '{16'h0008, 0, 1, 0, 0},
      '{16'h0004, 0, 1, 0, 1}, '{16'h0002, 0, 1, 0, 1}, '{16'h0001, 0, 2, 0, 1},
      '{16'h0001, 0, 1, 0, 0}, '{16'h0000, 0, 3, 0, 0}};
   always #20 clk_in = ~clk_in;
   plebk_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .primary_master_timer_in(tmr), .special_event_out(sev),
      .master_period_value_out(per), .high_side_output_in(hs), .low_side_output_in(ls),
      .blank_sources_in(srcs), .fault_in(flt), .current_limit_in(cl), .fault_out(flo),
      .current_limit_out(clo), .blanking_active_out(bla));
   plebk_stage stage_u (.clk_in(clk_in), .pwm_cmd_in(pwm), .trip_cmd_in(trip),
      .src_cmd_in(src), .high_side_out(hs), .low_side_out(ls), .fault_out(flt),
      .current_limit_out(cl), .sources_out(srcs));
   task close_out;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {16'h0, d};
      do begin @(posedge clk_in); n++; end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin err_total++; close_out(); end
      rd = rdat[15:0];
      cyc <= 0; stb <= 0; we <= 0;
      @(posedge clk_in);
   endtask
   // p0 applied first, p1 after the control write, p2 gap+1 cycles after p1; low cycles of both outputs counted
   task er(input logic [15:0] c, input logic [1:0] p0, p1, p2, input int gap,
           input logic [15:0] ef, ec);
      pwm <= p0;
      repeat (12) @(posedge clk_in);
      wb(1, 8'h08, c);
      pwm <= p1; fl = 0; cn = 0;
      for (int i = 0; i < 30; i++) begin
         @(posedge clk_in);
         if (i == gap) pwm <= p2;
         if (flo === 1'b0) fl++;
         if (clo === 1'b0) cn++;
      end
      chk("edge fault", ef, fl[15:0]);
      chk("edge limit", ec, cn[15:0]);
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      rst_in <= 0;
      wb(0, 8'h00, 0); chk("period reset", 16'hfff8, rd);
      chk("period port", 16'hfff8, per);
      wb(1, 8'h00, 16'h1234); wb(0, 8'h00, 0); chk("period", 16'h1234, rd);
      chk("period port", 16'h1234, per);
      wb(1, 8'h04, 16'h0030); wb(0, 8'h04, 0); chk("compare", 16'h0030, rd);
      tmr <= 16'h0030; repeat (2) @(posedge clk_in);
      chk("event", 1, {15'h0, sev});
      tmr <= 16'h0031; repeat (2) @(posedge clk_in);
      chk("no event", 0, {15'h0, sev});
      sel <= 4'h2;
      wb(1, 8'h04, 16'habcd);
      sel <= 4'h3;
      wb(0, 8'h04, 0);
      chk("byte lane", 16'hab30, rd);
      wb(1, 8'h08, 16'hffff); wb(0, 8'h08, 0); chk("control", 16'hfc3f, rd);
      wb(1, 8'h1c, 16'h5a5a); wb(0, 8'h1c, 0); chk("unmapped", 0, rd);
      $display("registers done");
      foreach (rows[i]) begin
         pwm <= rows[i].p; src <= rows[i].s;
         wb(1, 8'h10, {14'h0, rows[i].a});
         wb(1, 8'h08, rows[i].c);
         repeat (4) @(posedge clk_in);
         chk("fault", {15'h0, ~rows[i].m}, {15'h0, flo});
         chk("limit", {15'h0, ~rows[i].m}, {15'h0, clo});
         chk("active", {15'h0, rows[i].m}, {15'h0, bla});
      end
      $display("level blanking done");
      wb(1, 8'h0c, 16'hf005);
      wb(0, 8'h0c, 0);
      chk("interval", 16'h0005, rd);
      er(16'h8c00, 0, 2, 2, 99, 6, 6);
      er(16'h4c00, 2, 0, 0, 99, 6, 6);
      er(16'h2c00, 0, 1, 1, 99, 6, 6);
      er(16'h1c00, 1, 0, 0, 99, 6, 6);
      er(16'h0c00, 0, 3, 0, 5, 0, 0);
      er(16'h8800, 0, 2, 2, 99, 6, 0);
      er(16'h8400, 0, 2, 2, 99, 0, 6);
      er(16'hcc00, 0, 2, 0, 3, 10, 10);
      wb(1, 8'h0c, 16'h0000);
      er(16'h8c00, 0, 2, 0, 10, 1, 1);
      trip <= 0;
      repeat (3) @(posedge clk_in);
      chk("fault low", 0, {15'h0, flo});
      chk("limit low", 0, {15'h0, clo});
      trip <= 1;
      $display("edge blanking done");
      rst_in <= 1; repeat (4) @(posedge clk_in); rst_in <= 0;
      wb(0, 8'h00, 0); chk("period re-reset", 16'hfff8, rd);
      $display("second reset done");
      close_out();
   end
endmodule
